// file: bench/dfsi_asserts.sv
`include "dfsi_defines.svh"
module dfsi_asserts #(
  parameter int unsigned SLOT_CYC = 8
) (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic [7:0] addr, // address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [31:0] rdata, // read data
  input wire logic [11:0] temp_meas, // temperature
  input wire logic [15:0] lead_lag, // lead/lag
  input wire logic main_supply_on, // main present
  input wire logic main_supply_ok, // main in range
  input wire logic [1:0] nmt_state, // node state
  input wire logic bus_off, // bus-off
  input wire logic power_en, // power stage
  input wire logic supply_indicator_green, // led
  input wire logic supply_indicator_red, // led
  input wire logic network_indicator_green, // led
  input wire logic network_indicator_red, // led
  input wire logic irq // interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // register shadows
  // ****
  logic [11:0] tmax_r;
  logic [15:0] lag_r;
  logic trk_r;
  logic drv_r;
  wire logic [15:0] lag_abs = lead_lag[15] ? 16'h0 - lead_lag : lead_lag;
  wire logic over = temp_meas > tmax_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tmax_r <= `DFSI_TEMP_MAX_RST;
      lag_r <= `DFSI_LAG_LIM_RST;
      trk_r <= 1'h0;
      drv_r <= 1'h0;
    end else if (wr && addr == `DFSI_A_TEMP_MAX) begin
      tmax_r <= wdata[11:0];
    end else if (wr && addr == `DFSI_A_LAG_LIM) begin
      lag_r <= wdata[15:0];
    end else if (wr && addr == `DFSI_A_CTRL) begin
      trk_r <= wdata[`DFSI_CTRL_TRACK];
      drv_r <= wdata[`DFSI_CTRL_DRIVE];
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_temp_power_off: assert property (over |=> !power_en)
    else $error("power stage on while over temperature");
  chk_lag_power_off: assert property (trk_r && lag_abs > lag_r |=> !power_en)
    else $error("power stage on with lag past limit");
  chk_untracked_runs: assert property ((drv_r && !trk_r && !over)[*2] |=> power_en)
    else $error("power stage off with tracking loop disabled");
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read answer");
  chk_unmapped_zero: assert property (rd && addr >= 8'h2C |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_mask_drop: assert property (wr && addr == `DFSI_A_IRQ_EN && wdata == 32'h0 |=> ##1 !irq)
    else $error("interrupt high after mask");
  chk_supply_green: assert property ((main_supply_on && main_supply_ok)[*5] |->
    supply_indicator_green && !supply_indicator_red)
    else $error("supply led not solid green");
  chk_supply_red: assert property ((main_supply_on && !main_supply_ok)[*5] |->
    supply_indicator_red && !supply_indicator_green)
    else $error("supply led not solid red");
  chk_busoff_red: assert property (bus_off[*5] |-> network_indicator_red)
    else $error("network led not solid red");
  chk_oper_green: assert property ((nmt_state == 2'h2)[*5] |-> network_indicator_green)
    else $error("network led not solid green");
endmodule // dfsi_asserts

bind dfsi_top dfsi_asserts #(.SLOT_CYC(SLOT_CYC)) chk_u (
  .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .temp_meas(temp_meas), .lead_lag(lead_lag),
  .main_supply_on(main_supply_on), .main_supply_ok(main_supply_ok),
  .nmt_state(nmt_state), .bus_off(bus_off), .power_en(power_en),
  .supply_indicator_green(supply_indicator_green), .supply_indicator_red(supply_indicator_red),
  .network_indicator_green(network_indicator_green), .network_indicator_red(network_indicator_red),
  .irq(irq)
);

// file: bench/dfsi_net_model.sv
module dfsi_net_model (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic sync_on, // send SYNC
  input wire logic motion_cmd, // commanded steps
  input wire logic enc_step, // encoder moved
  output logic sync_rx, // SYNC pulse
  output logic stall_seen // stall found by polling
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // master side
  // ****
  logic [3:0] gap_r;
  logic [3:0] idle_r;
  // one SYNC every 10 cycles stays well inside a 2 us period
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_r <= 4'h0;
      sync_rx <= 1'h0;
      idle_r <= 4'h0;
    end else begin
      gap_r <= (gap_r == 4'h9) ? 4'h0 : gap_r + 4'h1;
      sync_rx <= sync_on && gap_r == 4'h9;
      idle_r <= (enc_step || !motion_cmd) ? 4'h0 : idle_r + {3'h0, idle_r != 4'hF};
    end
  end
  assign stall_seen = idle_r >= 4'h8;
endmodule // dfsi_net_model

// file: bench/tb_top.sv
`include "dfsi_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FRAME = 80;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [11:0] temp_meas = 12'h100;
  logic [15:0] lead_lag = 16'h0;
  logic [1:0] nmt_state = 2'h2;
  logic wr = 1'h0, rd = 1'h0, motion_cmd = 1'h0, enc_step = 1'h0, sync_on = 1'h0;
  logic main_supply_on = 1'h1, main_supply_ok = 1'h1, aux_supply_ok = 1'h1;
  logic bus_off = 1'h0, err_warn = 1'h0, guard_evt = 1'h0, hb_evt = 1'h0;
  logic [31:0] rdata;
  logic sync_rx, stall_seen, power_en, sg, sr, ng, nr, irq;
  int err_count = 0;
  int check_count = 0;
  always #50 core_clk = ~core_clk;
  dfsi_top #(.SLOT_CYC(8)) dut_u (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .temp_meas(temp_meas),
    .lead_lag(lead_lag), .motion_cmd(motion_cmd), .enc_step(enc_step),
    .main_supply_on(main_supply_on), .main_supply_ok(main_supply_ok),
    .aux_supply_ok(aux_supply_ok), .nmt_state(nmt_state), .bus_off(bus_off),
    .err_warn(err_warn), .guard_evt(guard_evt), .hb_evt(hb_evt), .sync_rx(sync_rx),
    .power_en(power_en), .supply_indicator_green(sg), .supply_indicator_red(sr),
    .network_indicator_green(ng), .network_indicator_red(nr), .irq(irq));
  dfsi_net_model net_u (.core_clk(core_clk), .rst(rst), .sync_on(sync_on),
    .motion_cmd(motion_cmd), .enc_step(enc_step), .sync_rx(sync_rx), .stall_seen(stall_seen));
  // ****
  // shared tasks
  // ****
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge core_clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'h0;
    #1 check("register", rdata & mask, exp);
  endtask
  // counts lit cycles over one whole pattern frame, so phase does not matter
  task automatic leds(input logic net, input int eg, input int er);
    int g;
    int r;
    g = 0;
    r = 0;
    tick(6);
    repeat (FRAME) begin
      @(posedge core_clk);
      #1;
      g += net ? (ng === 1'h1) : (sg === 1'h1);
      r += net ? (nr === 1'h1) : (sr === 1'h1);
    end
    check("green lit cycles", g, eg);
    check("red lit cycles", r, er);
  endtask
  task automatic pulse_evt(input logic hb);
    @(posedge core_clk);
    guard_evt <= !hb;
    hb_evt <= hb;
    @(posedge core_clk);
    guard_evt <= 1'h0;
    hb_evt <= 1'h0;
  endtask
  // ****
  // scenarios
  // ****
  task automatic s_regs();
    logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h24, 8'h20, 8'h30};
    logic [31:0] rv [8] = '{32'h0, `DFSI_TEMP_MAX_RST, `DFSI_LAG_LIM_RST, `DFSI_STALL_TO_RST,
      32'h0, 32'h0, 32'h0, 32'h0};
    wr_reg(8'h30, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) rd_chk(ra[i], 32'hFFFFFFFF, rv[i]);
  endtask
  task automatic s_temp();
    wr_reg(`DFSI_A_CTRL, 32'h2);
    @(posedge core_clk) temp_meas <= `DFSI_TEMP_MAX_RST + 12'h1;
    tick(3);
    #1 check("power_en", power_en, 32'h0);
    rd_chk(`DFSI_A_TEMP, 32'hFFFFFFFF, 32'h1C01);
    rd_chk(`DFSI_A_ERR_CODE, 32'hFF, `DFSI_ERR_TEMP);
    rd_chk(`DFSI_A_IRQ_STAT, 32'hFFFFFFFF, 32'h1);
    @(posedge core_clk) temp_meas <= `DFSI_TEMP_MAX_RST;
    wr_reg(`DFSI_A_IRQ_CLR, 32'h1F);
    tick(3);
    #1 check("power_en", power_en, 32'h1);
  endtask
  task automatic s_lock();
    wr_reg(`DFSI_A_IRQ_EN, 32'h2);
    wr_reg(`DFSI_A_CTRL, 32'h3);
    @(posedge core_clk) lead_lag <= 16'hFF00;
    tick(4);
    #1 check("power_en", power_en, 32'h1);
    @(posedge core_clk) lead_lag <= 16'hFEFF;
    tick(5);
    #1 check("power_en", power_en, 32'h0);
    check("irq", irq, 32'h1);
    rd_chk(`DFSI_A_STATUS, 32'hFFFFFFFF, 32'h87);
    rd_chk(`DFSI_A_ERR_CODE, 32'hFF, `DFSI_ERR_LOCK);
    @(posedge core_clk) lead_lag <= 16'h0;
    wr_reg(`DFSI_A_IRQ_EN, 32'h0);
    wr_reg(`DFSI_A_IRQ_CLR, 32'h2);
    rd_chk(`DFSI_A_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    wr_reg(`DFSI_A_CTRL, 32'h7);
    tick(3);
    #1 check("power_en", power_en, 32'h1);
    wr_reg(`DFSI_A_STALL_TO, 32'h5);
    @(posedge core_clk) motion_cmd <= 1'h1;
    for (int n = 0; n < 20 && power_en !== 1'h0; n++) tick(1);
    #1 check("power_en", power_en, 32'h0);
    if (power_en !== 1'h0) complete_run();
    rd_chk(`DFSI_A_ERR_CODE, 32'hFF, `DFSI_ERR_LOCK);
    wr_reg(`DFSI_A_CTRL, 32'h2);
    @(posedge core_clk) lead_lag <= 16'h7FFF;
    tick(12);
    #1 check("power_en", power_en, 32'h1);
    check("stall seen", stall_seen, 32'h1);
    rd_chk(`DFSI_A_STATUS, 32'h2, 32'h0);
    rd_chk(`DFSI_A_ERR_CODE, 32'hFF, `DFSI_ERR_NONE);
    @(posedge core_clk) lead_lag <= 16'h0;
    motion_cmd <= 1'h0;
  endtask
  task automatic s_supply();
    logic [2:0] sup [4] = '{3'h6, 3'h4, 3'h1, 3'h0};
    int eg [4] = '{FRAME, 0, FRAME / 2, 0};
    int er [4] = '{0, FRAME, 0, FRAME / 2};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) {main_supply_on, main_supply_ok, aux_supply_ok} <= sup[i];
      leds(1'h0, eg[i], er[i]);
    end
  endtask
  task automatic s_net();
    logic [1:0] st [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
    int eg [4] = '{FRAME, 8, FRAME / 2, 0};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk) nmt_state <= st[i];
      leds(1'h1, eg[i], 0);
    end
    @(posedge core_clk) nmt_state <= 2'h2;
    bus_off <= 1'h1;
    err_warn <= 1'h1;
    leds(1'h1, FRAME, FRAME);
    @(posedge core_clk) bus_off <= 1'h0;
    leds(1'h1, FRAME, 8);
    wr_reg(`DFSI_A_SYNC_PER, 32'h2);
    tick(30);
    leds(1'h1, FRAME, 24);
    @(posedge core_clk) sync_on <= 1'h1;
    tick(12);
    leds(1'h1, FRAME, 8);
    wr_reg(`DFSI_A_IRQ_EN, 32'h4);
    for (int h = 0; h < 2; h++) begin
      pulse_evt(h[0]);
      leds(1'h1, FRAME, 16);
      check("irq", irq, 32'h1);
      wr_reg(`DFSI_A_IRQ_CLR, 32'h4);
      leds(1'h1, FRAME, 8);
    end
  endtask
  initial begin
    tick(20);
    rst <= 1'h0;
    s_regs();
    s_temp();
    s_lock();
    s_supply();
    s_net();
    complete_run();
  end
endmodule // tb_top

// file: pkg/dfsi_blink_if.sv
interface dfsi_blink_if;
  logic flash;
  logic single;
  logic double;
  logic triple;
  modport gen (output flash, output single, output double, output triple);
  modport use_p (input flash, input single, input double, input triple);
endinterface

// file: pkg/dfsi_defines.svh
// Summary of operation
// - Power stage turns off when measured temperature exceeds the limit; readable status.
// - Lead/lag past limit or stall timeout disables power stage, raises locked rotor.
// - Locked rotor error only ever raised while the rotor tracking loop is enabled.
// - Locked rotor shown in tracking loop status bits and as an error code.
// - With tracking loop enabled a stopped or blocked shaft raises locked rotor.
// - Supply indicator: solid green main in range, flashing green on auxiliary supply.
// - Supply indicator: solid red main out of range, flashing red auxiliary bad.
// - Network indicator solid green while node is operational.
// - Network indicator single green flash while node is stopped.
// - Network indicator continuous green flashing while node is pre-operational.
// - Network indicator solid red while the CAN controller is bus-off.
// - Network indicator single red flash when an error counter reaches warning level.
// - Network indicator double red flash after guarding or heartbeat timeout event.
// - Network indicator triple red flash when SYNC misses the cycle period.
`ifndef DFSI_DEFINES_SVH
`define DFSI_DEFINES_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define DFSI_A_CTRL 8'h00
`define DFSI_A_TEMP_MAX 8'h04
`define DFSI_A_LAG_LIM 8'h08
`define DFSI_A_STALL_TO 8'h0C
`define DFSI_A_SYNC_PER 8'h10
`define DFSI_A_STATUS 8'h14
`define DFSI_A_ERR_CODE 8'h18
`define DFSI_A_IRQ_STAT 8'h1C
`define DFSI_A_IRQ_CLR 8'h20
`define DFSI_A_IRQ_EN 8'h24
`define DFSI_A_TEMP 8'h28

// ****************************************
// fields and reset values
// ****************************************
`define DFSI_CTRL_TRACK 0
`define DFSI_CTRL_DRIVE 1
`define DFSI_CTRL_FCLR 2
`define DFSI_TEMP_MAX_RST 12'hC00
`define DFSI_LAG_LIM_RST 16'h0100
`define DFSI_STALL_TO_RST 24'h0F4240
`define DFSI_EV_TEMP 0
`define DFSI_EV_LOCK 1
`define DFSI_EV_GUARD 2
`define DFSI_EV_SYNC 3
`define DFSI_EV_BUSOFF 4
`define DFSI_NEV 5
`define DFSI_ERR_NONE 8'h00
`define DFSI_ERR_LOCK 8'h01
`define DFSI_ERR_TEMP 8'h02

// ****************************************
// timing
// ****************************************
`define DFSI_CLK_HZ 10000000
`define DFSI_SLOT_MS 200
`define DFSI_SLOT_CYC (`DFSI_CLK_HZ / 1000 * `DFSI_SLOT_MS)
`define DFSI_US_CYC (`DFSI_CLK_HZ / 1000000)
`define DFSI_FRAME_SLOTS 4'hA

`endif

// file: pkg/dfsi_pkg.sv
package dfsi_pkg;
  typedef enum logic [1:0] {
    DFSI_NMT_STOP = 2'h0,
    DFSI_NMT_PREOP = 2'h1,
    DFSI_NMT_OPER = 2'h2
  } dfsi_nmt_t;
endpackage

// file: rtl/dfsi_blink.sv
`include "dfsi_defines.svh"
module dfsi_blink #(
  parameter int unsigned SLOT_CYC = `DFSI_SLOT_CYC
) (
  input wire logic core_clk, // clock
  input wire logic rst, // async reset
  dfsi_blink_if.gen pat // pattern levels
);
  logic [31:0] cyc_r;
  logic [3:0] slot_r;
  wire slot_end = (cyc_r == 32'(SLOT_CYC - 1));
  wire frame_end = (slot_r == `DFSI_FRAME_SLOTS - 4'h1);

  // ****************************************
  // shared slot timebase
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cyc_r <= 32'h0;
      slot_r <= 4'h0;
    end else begin
      cyc_r <= slot_end ? 32'h0 : cyc_r + 32'h1;
      if (slot_end) begin
        slot_r <= frame_end ? 4'h0 : slot_r + 4'h1;
      end
    end
  end

  // one-slot pulses at slots 0, 2, 4 of a ten-slot frame leave a long dark gap
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pat.flash <= 1'b0;
      pat.single <= 1'b0;
      pat.double <= 1'b0;
      pat.triple <= 1'b0;
    end else begin
      pat.flash <= ~slot_r[0];
      pat.single <= (slot_r == 4'h0);
      pat.double <= (slot_r == 4'h0) | (slot_r == 4'h2);
      pat.triple <= (slot_r == 4'h0) | (slot_r == 4'h2) | (slot_r == 4'h4);
    end
  end
endmodule // dfsi_blink

// file: rtl/dfsi_top.sv
// The plain strobed port and the address map were left to the implementer.
`include "dfsi_defines.svh"
module dfsi_top
  import dfsi_pkg::*;
#(
  parameter int unsigned SLOT_CYC = `DFSI_SLOT_CYC
) (
  input wire logic core_clk, // 10 MHz clock
  input wire logic rst, // async reset, active high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic [11:0] temp_meas, // power stage temperature
  input wire logic [15:0] lead_lag, // signed rotor/stator error
  input wire logic motion_cmd, // steps being commanded
  input wire logic enc_step, // encoder moved this cycle
  input wire logic main_supply_on, // main supply present
  input wire logic main_supply_ok, // main supply in range
  input wire logic aux_supply_ok, // auxiliary supply in range
  input wire logic [1:0] nmt_state, // network node state
  input wire logic bus_off, // CAN controller bus-off
  input wire logic err_warn, // error counter at warning level
  input wire logic guard_evt, // node guarding event pulse
  input wire logic hb_evt, // heartbeat consumer timeout pulse
  input wire logic sync_rx, // SYNC message received pulse
  output logic power_en, // power stage enable
  output logic supply_indicator_green, // supply indicator green
  output logic supply_indicator_red, // supply indicator red
  output logic network_indicator_green, // network indicator green
  output logic network_indicator_red, // network indicator red
  output logic irq // level interrupt
);

  // ****************************************
  // register file
  // ****************************************
  logic [2:0] ctrl_r;
  logic [11:0] temp_max_r;
  logic [15:0] lag_lim_r;
  logic [23:0] stall_to_r;
  logic [31:0] sync_per_r;
  logic [`DFSI_NEV-1:0] irq_en_r;
  logic [`DFSI_NEV-1:0] irq_st_r;

  wire wr_ctrl = wr & (addr == `DFSI_A_CTRL);
  wire wr_tmax = wr & (addr == `DFSI_A_TEMP_MAX);
  wire wr_lag = wr & (addr == `DFSI_A_LAG_LIM);
  wire wr_stall = wr & (addr == `DFSI_A_STALL_TO);
  wire wr_sync = wr & (addr == `DFSI_A_SYNC_PER);
  wire wr_iclr = wr & (addr == `DFSI_A_IRQ_CLR);
  wire wr_ien = wr & (addr == `DFSI_A_IRQ_EN);
  wire fault_clr = wr_ctrl & wdata[`DFSI_CTRL_FCLR];
  wire track_en = ctrl_r[`DFSI_CTRL_TRACK];
  wire drive_en = ctrl_r[`DFSI_CTRL_DRIVE];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 3'h0;
      temp_max_r <= `DFSI_TEMP_MAX_RST;
      lag_lim_r <= `DFSI_LAG_LIM_RST;
      stall_to_r <= `DFSI_STALL_TO_RST;
      sync_per_r <= 32'h0;
      irq_en_r <= '0;
    end else begin
      // fault clear bit is a pulse and never stored
      if (wr_ctrl) ctrl_r <= {1'b0, wdata[1:0]};
      if (wr_tmax) temp_max_r <= wdata[11:0];
      if (wr_lag) lag_lim_r <= wdata[15:0];
      if (wr_stall) stall_to_r <= wdata[23:0];
      if (wr_sync) sync_per_r <= wdata;
      if (wr_ien) irq_en_r <= wdata[`DFSI_NEV-1:0];
    end
  end

  // ****************************************
  // temperature supervision
  // ****************************************
  logic over_d_r;
  wire temp_over = (temp_meas > temp_max_r);

  // ****************************************
  // locked rotor detection
  // ****************************************
  logic [23:0] stall_cnt_r;
  logic lock_r;
  logic [7:0] err_code_r;
  wire [15:0] lag_neg = 16'(~lead_lag + 16'h1);
  wire [15:0] lag_mag = lead_lag[15] ? lag_neg : lead_lag;
  wire lag_over = (lag_mag > lag_lim_r);
  wire stall_run = track_en & motion_cmd & ~enc_step;
  wire stall_sat = (stall_cnt_r == 24'hFFFFFF);
  wire stall_hit = stall_run & (stall_to_r != 24'h0) & (stall_cnt_r >= stall_to_r);
  // gated by the loop enable so no lock can appear in bypass operation
  wire lock_set = track_en & (lag_over | stall_hit);
  wire [23:0] stall_cnt_nxt = ~stall_run ? 24'h0 :
                              stall_sat ? stall_cnt_r : stall_cnt_r + 24'h1;
  wire lock_nxt = lock_set | (lock_r & ~fault_clr & track_en);
  wire [7:0] err_code_nxt = lock_nxt ? `DFSI_ERR_LOCK :
                            temp_over ? `DFSI_ERR_TEMP : `DFSI_ERR_NONE;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stall_cnt_r <= 24'h0;
      lock_r <= 1'b0;
      err_code_r <= `DFSI_ERR_NONE;
      over_d_r <= 1'b0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
      lock_r <= lock_nxt;
      err_code_r <= err_code_nxt;
      over_d_r <= temp_over;
    end
  end

  // the stage drops in the same cycle the fault is latched, not one later
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_en <= 1'b0;
    end else begin
      power_en <= drive_en & ~temp_over & ~lock_nxt;
    end
  end

  // ****************************************
  // SYNC supervision
  // ****************************************
  logic [3:0] us_cnt_r;
  logic [31:0] sync_cnt_r;
  logic sync_to_r;
  wire us_tick = (us_cnt_r == 4'(`DFSI_US_CYC - 1));
  wire sync_mon = (sync_per_r != 32'h0);
  wire sync_exp = sync_mon & ~sync_rx & (sync_cnt_r >= sync_per_r);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      us_cnt_r <= 4'h0;
      sync_cnt_r <= 32'h0;
      sync_to_r <= 1'b0;
    end else begin
      us_cnt_r <= us_tick ? 4'h0 : us_cnt_r + 4'h1;
      if (sync_rx | ~sync_mon) begin
        sync_cnt_r <= 32'h0;
      end else if (us_tick & ~sync_exp) begin
        sync_cnt_r <= sync_cnt_r + 32'h1;
      end
      sync_to_r <= sync_exp | (sync_to_r & ~sync_rx & sync_mon);
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  logic bus_off_d_r;
  logic sync_to_d_r;
  logic lock_d_r;
  wire [`DFSI_NEV-1:0] ev;
  assign ev[`DFSI_EV_TEMP] = temp_over & ~over_d_r;
  // rising edge only, so a held lock does not re-set the bit after software clears it
  assign ev[`DFSI_EV_LOCK] = lock_r & ~lock_d_r;
  assign ev[`DFSI_EV_GUARD] = guard_evt | hb_evt;
  assign ev[`DFSI_EV_SYNC] = sync_to_r & ~sync_to_d_r;
  assign ev[`DFSI_EV_BUSOFF] = bus_off & ~bus_off_d_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_off_d_r <= 1'b0;
      sync_to_d_r <= 1'b0;
      lock_d_r <= 1'b0;
    end else begin
      bus_off_d_r <= bus_off;
      sync_to_d_r <= sync_to_r;
      lock_d_r <= lock_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DFSI_NEV; gi++) begin : g_sticky
      // a new event in the clearing cycle keeps the bit set
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          irq_st_r[gi] <= 1'b0;
        end else begin
          irq_st_r[gi] <= ev[gi] | (irq_st_r[gi] & ~(wr_iclr & wdata[gi]));
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  // ****************************************
  // indicators
  // ****************************************
  dfsi_blink_if pat ();

  dfsi_blink #(.SLOT_CYC(SLOT_CYC)) u_blink (
    .core_clk(core_clk),
    .rst(rst),
    .pat(pat)
  );

  wire sup_g = main_supply_on ? main_supply_ok : (aux_supply_ok & pat.flash);
  wire sup_r = main_supply_on ? ~main_supply_ok : (~aux_supply_ok & pat.flash);
  wire net_g = (nmt_state == DFSI_NMT_OPER) ? 1'b1 :
               (nmt_state == DFSI_NMT_STOP) ? pat.single :
               (nmt_state == DFSI_NMT_PREOP) ? pat.flash : 1'b0;
  // the double flash stays until software clears the guard event bit
  wire net_r = bus_off ? 1'b1 :
               sync_to_r ? pat.triple :
               irq_st_r[`DFSI_EV_GUARD] ? pat.double :
               err_warn ? pat.single : 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      supply_indicator_green <= 1'b0;
      supply_indicator_red <= 1'b0;
      network_indicator_green <= 1'b0;
      network_indicator_red <= 1'b0;
    end else begin
      supply_indicator_green <= sup_g;
      supply_indicator_red <= sup_r;
      network_indicator_green <= net_g;
      network_indicator_red <= net_r;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  wire [31:0] status_w = {24'h0, nmt_state, err_warn, bus_off, sync_to_r,
                          lag_over, lock_r, track_en};
  wire [31:0] temp_w = {19'h0, temp_over, temp_meas};
  wire [31:0] rd_val =
    (addr == `DFSI_A_CTRL) ? {29'h0, ctrl_r} :
    (addr == `DFSI_A_TEMP_MAX) ? {20'h0, temp_max_r} :
    (addr == `DFSI_A_LAG_LIM) ? {16'h0, lag_lim_r} :
    (addr == `DFSI_A_STALL_TO) ? {8'h0, stall_to_r} :
    (addr == `DFSI_A_SYNC_PER) ? sync_per_r :
    (addr == `DFSI_A_STATUS) ? status_w :
    (addr == `DFSI_A_ERR_CODE) ? {24'h0, err_code_r} :
    (addr == `DFSI_A_IRQ_STAT) ? {27'h0, irq_st_r} :
    (addr == `DFSI_A_IRQ_EN) ? {27'h0, irq_en_r} :
    (addr == `DFSI_A_TEMP) ? temp_w : 32'h0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else begin
      rdata <= rd ? rd_val : 32'h0;
    end
  end
endmodule // dfsi_top
